// [inc/mac_ctl_pkg.sv]
// Shared constants and carriers for the MAC filter and retry controller
package mac_ctl_pkg;
  // Register indices
  localparam logic [7:0] OFS_CONTROL = 8'h01;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h02;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h03;
  // Control register reset value and writable bits
  localparam logic [31:0] CTRL_RESET = 32'h0004_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h80BF_ADC0;
  // Control bit positions
  localparam int B_RX_ALL = 31;
  localparam int B_MC_PASS = 19;
  localparam int B_PROMISC = 18;
  localparam int B_INVERSE = 17;
  localparam int B_BAD_OK = 16;
  localparam int B_HASH_ONLY = 15;
  localparam int B_HASH_PERF = 13;
  localparam int B_BC_REJECT = 11;
  localparam int B_RETRY_DIS = 10;
  localparam int B_PAD_STRIP = 8;
  // Interrupt status bits
  localparam int IRQ_W = 4;
  localparam int I_RX_OK = 0;
  localparam int I_RX_DROP = 1;
  localparam int I_TX_ERR = 2;
  localparam int I_WAKE = 3;
  // Frame figures
  localparam logic [15:0] MIN_DATA = 16'h002E;
  localparam logic [15:0] HDR_LEN = 16'h000E;
  localparam logic [47:0] BROADCAST_REJECT_ADDR = 48'hFFFF_FFFF_FFFF;
  localparam logic [4:0] MAX_TRIES = 5'h10;
  localparam logic [4:0] ONE_TRY = 5'h01;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [47:0] dest;
    logic [15:0] len_field;
    logic [15:0] frame_len;
    logic [5:0] hash_idx;
    logic runt;
    logic collided;
    logic wake_frame;
  } rx_desc_t;

  typedef struct packed {
    logic deliver;
    logic addr_pass;
    logic strip;
    logic [15:0] keep_len;
  } rx_verdict_t;

  typedef struct packed {
    logic retry_error;
    logic [4:0] attempts;
  } tx_status_t;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_BUSY = 1'b1
  } tx_state_t;
endpackage

// [rtl/mac_filter_retry.sv]
// Receive address filter, pad strip and transmit retry controller
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps

// Overview of operation
// - Bad-frame accept delivers runt and collided frames
// - Hash-only filters individual and multicast by hash
// - Hash/perfect and hash-only clear: exact station address match
// - Hash/perfect set: multicast checked in hash
// - Hash/perfect plus hash-only: individual by hash
// - Hash/perfect without hash-only: individual exact
// - Broadcast reject drops broadcast, else forwarded
// - Broadcast wake frame wakes despite reject
// - Retry disable allows one attempt only
// - Retry disabled collision: abandon, report error
// - Retry enabled: up to sixteen attempts
// - Pad strip removes pad below 46 bytes
// - Stripped frames also lose their FCS
// - Length 46 or more passes unchanged
// - Pad strip off passes frames unchanged
// - Promiscuous accepts all good frames, set after reset
// - Inverse filter only in perfect mode
module mac_filter_retry (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [47:0] station_addr,
  input wire logic [63:0] hash_table,
  input wire logic wake_frame_enable,
  input wire logic rx_desc_valid,
  input wire mac_ctl_pkg::rx_desc_t rx_desc,
  output logic rx_verdict_valid,
  output mac_ctl_pkg::rx_verdict_t rx_verdict,
  output logic wake_event,
  input wire logic tx_start,
  input wire logic tx_collision,
  input wire logic tx_success,
  output logic tx_retry,
  output logic tx_status_valid,
  output mac_ctl_pkg::tx_status_t tx_status,
  output logic irq
);

  logic [31:0] ctrl_ff;
  logic [mac_ctl_pkg::IRQ_W-1:0] stat_ff;
  logic [mac_ctl_pkg::IRQ_W-1:0] mask_ff;
  logic [31:0] rdata_ff;
  logic irq_ff;
  logic vval_ff;
  mac_ctl_pkg::rx_verdict_t verd_ff;
  logic wake_ff;
  mac_ctl_pkg::tx_state_t tx_st_ff;
  logic [4:0] tries_ff;
  logic retry_ff;
  logic tval_ff;
  mac_ctl_pkg::tx_status_t tstat_ff;

  // Register decode
  wire sel_ctrl = reg_addr == mac_ctl_pkg::OFS_CONTROL;
  wire sel_stat = reg_addr == mac_ctl_pkg::OFS_IRQ_STAT;
  wire sel_mask = reg_addr == mac_ctl_pkg::OFS_IRQ_MASK;
  wire wr_ctrl = reg_wr && sel_ctrl;
  wire wr_mask = reg_wr && sel_mask;
  wire rd_stat = reg_rd && sel_stat;

  // Control fields
  wire rx_all = ctrl_ff[mac_ctl_pkg::B_RX_ALL];
  wire mc_pass = ctrl_ff[mac_ctl_pkg::B_MC_PASS];
  wire promisc = ctrl_ff[mac_ctl_pkg::B_PROMISC];
  wire inverse = ctrl_ff[mac_ctl_pkg::B_INVERSE];
  wire bad_ok = ctrl_ff[mac_ctl_pkg::B_BAD_OK];
  wire hash_only = ctrl_ff[mac_ctl_pkg::B_HASH_ONLY];
  wire hash_perf = ctrl_ff[mac_ctl_pkg::B_HASH_PERF];
  wire bc_reject = ctrl_ff[mac_ctl_pkg::B_BC_REJECT];
  wire retry_dis = ctrl_ff[mac_ctl_pkg::B_RETRY_DIS];
  wire pad_strip = ctrl_ff[mac_ctl_pkg::B_PAD_STRIP];

  // Reserved bits never store a value
  wire [31:0] nxt_ctrl = reg_wdata & mac_ctl_pkg::CTRL_WMASK;

  // Read data mux, unmapped addresses read zero
  wire [31:0] rd_mux =
    sel_ctrl ? ctrl_ff :
    sel_stat ? {{(32 - mac_ctl_pkg::IRQ_W){1'b0}}, stat_ff} :
    sel_mask ? {{(32 - mac_ctl_pkg::IRQ_W){1'b0}}, mask_ff} :
    mac_ctl_pkg::ZERO_WORD;

  // Address class of the incoming frame
  wire is_broadcast_reject = rx_desc.dest == mac_ctl_pkg::BROADCAST_REJECT_ADDR;
  wire is_mcast = rx_desc.dest[0] && !is_broadcast_reject;
  wire exact_hit = rx_desc.dest == station_addr;
  wire hash_hit = hash_table[rx_desc.hash_idx];
  wire is_bad = rx_desc.runt || rx_desc.collided;

  // Filter mode selection
  wire mc_by_hash = hash_perf || hash_only;
  wire ia_by_hash = hash_only;
  wire perfect_mode = !hash_perf && !hash_only;
  wire invert = inverse && perfect_mode;

  // Individual and multicast checks
  wire ia_raw = ia_by_hash ? hash_hit : exact_hit;
  wire mc_raw = mc_by_hash ? hash_hit : exact_hit;
  wire ia_ok = ia_raw ^ invert;
  wire mc_ok = mc_pass || (mc_raw ^ invert);
  wire bc_ok = !bc_reject;

  // Address verdict, promiscuous accepts everything
  wire addr_ok = promisc ? 1'b1 :
    is_broadcast_reject ? bc_ok :
    is_mcast ? mc_ok : ia_ok;

  // Bad frames pass only when allowed
  wire bad_ok_now = !is_bad || bad_ok;
  wire deliver = (addr_ok || rx_all) && bad_ok_now;

  // Pad and FCS strip below the minimum data length
  wire short_len = rx_desc.len_field < mac_ctl_pkg::MIN_DATA;
  wire do_strip = pad_strip && short_len;
  wire [15:0] strip_len = rx_desc.len_field + mac_ctl_pkg::HDR_LEN;
  wire [15:0] keep_len = do_strip ? strip_len : rx_desc.frame_len;

  // Broadcast wake frames wake regardless of reject
  wire wake_hit = wake_frame_enable && rx_desc.wake_frame && is_broadcast_reject;

  // Transmit attempt decisions
  wire tx_busy = tx_st_ff == mac_ctl_pkg::TX_BUSY;
  wire last_try = retry_dis || tries_ff == mac_ctl_pkg::MAX_TRIES;
  wire coll_now = tx_busy && tx_collision;
  wire give_up = coll_now && last_try;
  wire try_again = coll_now && !last_try;
  wire tx_done = tx_busy && tx_success && !tx_collision;
  wire [4:0] nxt_tries = tries_ff + mac_ctl_pkg::ONE_TRY;

  // Interrupt events
  wire rx_evt = ce && rx_desc_valid;
  wire [mac_ctl_pkg::IRQ_W-1:0] events = {
    rx_evt && wake_hit,
    give_up,
    rx_evt && !deliver,
    rx_evt && deliver
  };
  wire [mac_ctl_pkg::IRQ_W-1:0] clr = rd_stat ? stat_ff : '0;
  wire [mac_ctl_pkg::IRQ_W-1:0] nxt_stat = (stat_ff & ~clr) | events;
  wire nxt_irq = |(nxt_stat & mask_ff);

  // Register file and read port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_ff <= mac_ctl_pkg::CTRL_RESET;
      mask_ff <= '0;
      stat_ff <= '0;
      rdata_ff <= mac_ctl_pkg::ZERO_WORD;
      irq_ff <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_ff <= nxt_ctrl;
      end
      if (wr_mask) begin
        mask_ff <= reg_wdata[mac_ctl_pkg::IRQ_W-1:0];
      end
      stat_ff <= nxt_stat;
      rdata_ff <= reg_rd ? rd_mux : mac_ctl_pkg::ZERO_WORD;
      irq_ff <= nxt_irq;
    end
  end

  // Receive verdict, one cycle after the descriptor
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vval_ff <= 1'b0;
      verd_ff <= '0;
      wake_ff <= 1'b0;
    end else if (ce) begin
      vval_ff <= rx_desc_valid;
      wake_ff <= rx_desc_valid && wake_hit;
      if (rx_desc_valid) begin
        verd_ff <= '{deliver: deliver, addr_pass: addr_ok,
                     strip: do_strip, keep_len: keep_len};
      end
    end
  end

  // Transmit retry state machine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_st_ff <= mac_ctl_pkg::TX_IDLE;
      tries_ff <= '0;
      retry_ff <= 1'b0;
      tval_ff <= 1'b0;
      tstat_ff <= '0;
    end else if (ce) begin
      retry_ff <= 1'b0;
      tval_ff <= 1'b0;
      unique case (tx_st_ff)
        mac_ctl_pkg::TX_IDLE: begin
          if (tx_start) begin
            tx_st_ff <= mac_ctl_pkg::TX_BUSY;
            tries_ff <= mac_ctl_pkg::ONE_TRY;
          end
        end
        mac_ctl_pkg::TX_BUSY: begin
          if (give_up) begin
            tx_st_ff <= mac_ctl_pkg::TX_IDLE;
            tval_ff <= 1'b1;
            tstat_ff <= '{retry_error: 1'b1, attempts: tries_ff};
          end else if (try_again) begin
            tries_ff <= nxt_tries;
            retry_ff <= 1'b1;
          end else if (tx_done) begin
            tx_st_ff <= mac_ctl_pkg::TX_IDLE;
            tval_ff <= 1'b1;
            tstat_ff <= '{retry_error: 1'b0, attempts: tries_ff};
          end
        end
      endcase
    end
  end

  // Output drive
  assign reg_rdata = rdata_ff;
  assign irq = irq_ff;
  assign rx_verdict_valid = vval_ff;
  assign rx_verdict = verd_ff;
  assign wake_event = wake_ff;
  assign tx_retry = retry_ff;
  assign tx_status_valid = tval_ff;
  assign tx_status = tstat_ff;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence rx_in_s;
    ce && rx_desc_valid;
  endsequence

  sequence coll_s;
    ce && tx_busy && tx_collision;
  endsequence

  sequence err_out_s;
    tx_status_valid && tx_status.retry_error && !tx_retry;
  endsequence

  promisc_accept_a: assert property (
    rx_in_s and promisc && !is_bad |=> rx_verdict_valid && rx_verdict.deliver)
    else $error("promiscuous frame not delivered");

  bad_frame_a: assert property (
    rx_in_s and is_bad |=> rx_verdict.deliver == ($past(addr_ok || rx_all) && $past(bad_ok)))
    else $error("bad frame delivery wrong");

  broadcast_reject_reject_a: assert property (
    rx_in_s and is_broadcast_reject && !promisc && !rx_all && !is_bad
    |=> rx_verdict.deliver == !$past(bc_reject))
    else $error("broadcast handling wrong");

  wake_broadcast_reject_a: assert property (
    rx_in_s and wake_frame_enable && rx_desc.wake_frame && is_broadcast_reject |=> wake_event)
    else $error("broadcast wake frame missed");

  perfect_mode_a: assert property (
    rx_in_s and perfect_mode && !inverse && !promisc && !rx_all && !is_bad && !is_broadcast_reject
    && !rx_desc.dest[0] |=> rx_verdict.deliver == $past(exact_hit))
    else $error("perfect filter mismatch");

  hash_only_a: assert property (
    rx_in_s and hash_only && !promisc && !rx_all && !is_bad && !is_broadcast_reject && !mc_pass
    |=> rx_verdict.deliver == $past(hash_hit))
    else $error("hash-only filter mismatch");

  pad_strip_a: assert property (
    rx_in_s and pad_strip && short_len
    |=> rx_verdict.strip && rx_verdict.keep_len == $past(strip_len))
    else $error("pad not stripped");

  no_strip_a: assert property (
    rx_in_s and !(pad_strip && short_len)
    |=> !rx_verdict.strip && rx_verdict.keep_len == $past(rx_desc.frame_len))
    else $error("frame modified without strip");

  one_attempt_a: assert property (
    coll_s and retry_dis |=> err_out_s and !tx_busy)
    else $error("retry disable allowed a retry");

  sixteen_try_a: assert property (
    coll_s and !retry_dis && tries_ff < mac_ctl_pkg::MAX_TRIES |=> tx_retry && !tx_status_valid)
    else $error("retry not issued");

  retry_cap_a: assert property (
    coll_s and tries_ff == mac_ctl_pkg::MAX_TRIES |=> err_out_s)
    else $error("retry error not reported");

  mc_hash_a: assert property (
    rx_in_s and hash_perf && is_mcast && !mc_pass && !promisc && !rx_all && !is_bad
    |=> rx_verdict.deliver == $past(hash_hit))
    else $error("multicast hash filter mismatch");

  hash_perf_ia_a: assert property (
    rx_in_s and hash_perf && !hash_only && !promisc && !rx_all && !is_bad && !rx_desc.dest[0]
    |=> rx_verdict.deliver == $past(exact_hit))
    else $error("individual perfect filter mismatch");

  inverse_perf_a: assert property (
    rx_in_s and inverse && !hash_perf && !hash_only && !promisc && !rx_all && !is_bad
    && !rx_desc.dest[0] |=> rx_verdict.deliver == !$past(exact_hit))
    else $error("inverse filter mismatch");

  reserved_zero_a: assert property (
    (ctrl_ff & ~mac_ctl_pkg::CTRL_WMASK) == mac_ctl_pkg::ZERO_WORD)
    else $error("reserved control bit set");

endmodule

// [tb/fabric_model.sv]
// Switch fabric side model: receive descriptors and transmit attempt outcomes
`timescale 1ns/1ps
module fabric_model (
  input wire logic clk,
  input wire logic tx_start,
  input wire logic tx_retry,
  output logic rx_desc_valid,
  output mac_ctl_pkg::rx_desc_t rx_desc,
  output logic tx_collision,
  output logic tx_success
);
  // Collisions still to be reported before an attempt succeeds
  int left;
  initial begin
    rx_desc_valid = 1'b0;
    rx_desc = '0;
    tx_collision = 1'b0;
    tx_success = 1'b0;
    left = 0;
  end
  // Hands one descriptor over, then scrambles the idle lines
  task automatic send(input mac_ctl_pkg::rx_desc_t d);
    @(posedge clk);
    rx_desc_valid <= 1'b1;
    rx_desc <= d;
    @(posedge clk);
    rx_desc_valid <= 1'b0;
    rx_desc <= ~d;
  endtask
  // Answers every attempt one cycle later with a collision or success
  always @(posedge clk) begin
    tx_collision <= 1'b0;
    tx_success <= 1'b0;
    if (tx_start || tx_retry) begin
      if (left > 0) begin
        tx_collision <= 1'b1;
        left <= left - 1;
      end else begin
        tx_success <= 1'b1;
      end
    end
  end
endmodule

// [tb/mac_filter_retry_tb_top.sv]
// Self-checking bench for the MAC filter and retry controller
`timescale 1ns/1ps
module mac_filter_retry_tb_top;
  logic clk, sys_rst, ce, reg_wr, reg_rd, wake_frame_enable, tx_start;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic rx_desc_valid, rx_verdict_valid, wake_event, tx_collision, tx_success;
  logic tx_retry, tx_status_valid, irq;
  mac_ctl_pkg::rx_desc_t rx_desc;
  mac_ctl_pkg::rx_verdict_t rx_verdict;
  mac_ctl_pkg::tx_status_t tx_status;
  int bad_count, compares, cycles;

  mac_filter_retry dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .station_addr(48'h0000_0000_0002), .hash_table(64'h0000_0000_0000_0020),
    .wake_frame_enable(wake_frame_enable), .rx_desc_valid(rx_desc_valid),
    .rx_desc(rx_desc), .rx_verdict_valid(rx_verdict_valid), .rx_verdict(rx_verdict),
    .wake_event(wake_event), .tx_start(tx_start), .tx_collision(tx_collision),
    .tx_success(tx_success), .tx_retry(tx_retry), .tx_status_valid(tx_status_valid),
    .tx_status(tx_status), .irq(irq));
  fabric_model fab (.clk(clk), .tx_start(tx_start), .tx_retry(tx_retry),
    .rx_desc_valid(rx_desc_valid), .rx_desc(rx_desc), .tx_collision(tx_collision),
    .tx_success(tx_success));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches %0d of %0d compares", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // One received frame with its expected delivery
  task automatic rxc(input logic [47:0] da, input logic [5:0] h, input logic [15:0] len,
                     input logic runt, input logic wk, input logic exp);
    fab.send('{da, len, 16'h0040, h, runt, 1'b0, wk});
    #1 chk("verdict_valid", rx_verdict_valid, 1);
    chk("deliver", rx_verdict.deliver, exp);
  endtask
  // One transmit frame meeting n collisions
  task automatic txc(input int n, input logic err, input logic [4:0] att);
    fab.left = n;
    @(posedge clk);
    tx_start <= 1'b1;
    @(posedge clk);
    tx_start <= 1'b0;
    for (int i = 0; i < 100 && tx_status_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("status_valid", tx_status_valid, 1);
    chk("retry_error", tx_status.retry_error, err);
    chk("attempts", tx_status.attempts, att);
  endtask

  task automatic regs_test;
    // A write while the clock enable is low must not land
    ce <= 1'b0;
    wr(mac_ctl_pkg::OFS_CONTROL, 32'h0000_0000);
    ce <= 1'b1;
    rd(mac_ctl_pkg::OFS_CONTROL, v);
    chk("ctl reset", v, mac_ctl_pkg::CTRL_RESET);
    wr(mac_ctl_pkg::OFS_CONTROL, 32'hFFFF_FFFF);
    rd(mac_ctl_pkg::OFS_CONTROL, v);
    chk("ctl reserved", v, mac_ctl_pkg::CTRL_WMASK);
    rd(8'h7F, v);
    chk("unmapped", v, 32'h0000_0000);
    wr(mac_ctl_pkg::OFS_CONTROL, mac_ctl_pkg::CTRL_RESET);
    wr(mac_ctl_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    rxc(48'h0000_0000_0009, 6'h06, 16'h0040, 1'b0, 1'b0, 1'b1);
    @(posedge clk);
    #1 chk("irq", irq, 1);
    wr(mac_ctl_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    @(posedge clk);
    #1 chk("irq masked", irq, 0);
    rd(mac_ctl_pkg::OFS_IRQ_STAT, v);
    chk("status", v, 32'h0000_0001);
    rd(mac_ctl_pkg::OFS_IRQ_STAT, v);
    chk("status cleared", v, 32'h0000_0000);
  endtask
  task automatic filter_test;
    wr(mac_ctl_pkg::OFS_CONTROL, 32'h0000_0000);
    rxc(48'h0000_0000_0002, 6'h06, 16'h0040, 1'b0, 1'b0, 1'b1);
    rxc(48'h0000_0000_0004, 6'h05, 16'h0040, 1'b0, 1'b0, 1'b0);
    rxc(48'hFFFF_FFFF_FFFF, 6'h06, 16'h0040, 1'b0, 1'b0, 1'b1);
    rxc(48'h0000_0000_0002, 6'h06, 16'h0040, 1'b1, 1'b0, 1'b0);
    wr(mac_ctl_pkg::OFS_CONTROL, 32'h0001_0000);
    rxc(48'h0000_0000_0002, 6'h06, 16'h0040, 1'b1, 1'b0, 1'b1);
    wr(mac_ctl_pkg::OFS_CONTROL, 32'h0000_2000);
    rxc(48'h0000_0000_0001, 6'h05, 16'h0040, 1'b0, 1'b0, 1'b1);
    rxc(48'h0000_0000_0001, 6'h06, 16'h0040, 1'b0, 1'b0, 1'b0);
    rxc(48'h0000_0000_0002, 6'h06, 16'h0040, 1'b0, 1'b0, 1'b1);
    wr(mac_ctl_pkg::OFS_CONTROL, 32'h0000_A000);
    rxc(48'h0000_0000_0002, 6'h06, 16'h0040, 1'b0, 1'b0, 1'b0);
    rxc(48'h0000_0000_0004, 6'h05, 16'h0040, 1'b0, 1'b0, 1'b1);
    wr(mac_ctl_pkg::OFS_CONTROL, 32'h0000_8000);
    rxc(48'h0000_0000_0001, 6'h05, 16'h0040, 1'b0, 1'b0, 1'b1);
    wr(mac_ctl_pkg::OFS_CONTROL, 32'h0000_0800);
    rxc(48'hFFFF_FFFF_FFFF, 6'h06, 16'h0040, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    wake_frame_enable <= 1'b1;
    rxc(48'hFFFF_FFFF_FFFF, 6'h06, 16'h0040, 1'b0, 1'b1, 1'b0);
    chk("wake", wake_event, 1);
    // Inverse filtering, then ignored outside perfect mode
    wr(mac_ctl_pkg::OFS_CONTROL, 32'h0002_0000);
    rxc(48'h0000_0000_0002, 6'h06, 16'h0040, 1'b0, 1'b0, 1'b0);
    rxc(48'h0000_0000_0004, 6'h06, 16'h0040, 1'b0, 1'b0, 1'b1);
    wr(mac_ctl_pkg::OFS_CONTROL, 32'h0002_2000);
    rxc(48'h0000_0000_0002, 6'h06, 16'h0040, 1'b0, 1'b0, 1'b1);
    // Receive-all and pass-all-multicast
    wr(mac_ctl_pkg::OFS_CONTROL, 32'h8000_0000);
    rxc(48'h0000_0000_0004, 6'h06, 16'h0040, 1'b0, 1'b0, 1'b1);
    chk("addr_pass", rx_verdict.addr_pass, 0);
    wr(mac_ctl_pkg::OFS_CONTROL, 32'h0008_0000);
    rxc(48'h0000_0000_0001, 6'h06, 16'h0040, 1'b0, 1'b0, 1'b1);
  endtask
  task automatic pad_test;
    rxc(48'h0000_0000_0002, 6'h06, 16'h000A, 1'b0, 1'b0, 1'b1);
    chk("keep_len off", rx_verdict.keep_len, 16'h0040);
    wr(mac_ctl_pkg::OFS_CONTROL, 32'h0000_0100);
    rxc(48'h0000_0000_0002, 6'h06, 16'h000A, 1'b0, 1'b0, 1'b1);
    chk("strip", rx_verdict.strip, 1);
    chk("keep_len", rx_verdict.keep_len, 16'h0018);
    rxc(48'h0000_0000_0002, 6'h06, mac_ctl_pkg::MIN_DATA, 1'b0, 1'b0, 1'b1);
    chk("keep_len 46", rx_verdict.keep_len, 16'h0040);
  endtask
  task automatic tx_test;
    txc(15, 1'b0, 5'h10);
    txc(16, 1'b1, 5'h10);
    wr(mac_ctl_pkg::OFS_CONTROL, 32'h0000_0400);
    txc(1, 1'b1, 5'h01);
    txc(0, 1'b0, 5'h01);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      print_verdict;
    end
  end
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, wake_frame_enable, tx_start} = 4'h0;
    ce = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    regs_test;
    filter_test;
    pad_test;
    tx_test;
    print_verdict;
  end
endmodule
